// ===== ppwp_pkg.sv
// Package with the register map, field layout and reset values of the protection block.
package ppwp_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned IDX_W = 5;
    // Register offsets.
    localparam logic [7:0] OFF_CLEAR = 8'h00;
    localparam logic [7:0] OFF_SET = 8'h04;
    // Field positions.
    localparam int unsigned EVENT_BIT = 1;
    localparam int unsigned SERIAL_LSB = 2;
    localparam int unsigned SERIAL_N = 6;
    localparam int unsigned TIMER_LSB = 8;
    localparam int unsigned TIMER_N = 8;
    localparam int unsigned ANALOG_LSB = 16;
    localparam int unsigned ANALOG_N = 3;
    localparam int unsigned TOUCH_BIT = 19;
    // Bits that hold a peripheral's protection state.
    localparam logic [31:0] PROT_MASK = 32'h000FFFFE;
    // Reset value of the register as read back.
    localparam logic [31:0] RESET_VALUE = 32'h00800000;
    // Constant part of the read value (bits that no peripheral owns).
    localparam logic [31:0] FIXED_READ = RESET_VALUE & ~PROT_MASK;
    localparam logic [31:0] STATE_RESET = RESET_VALUE & PROT_MASK;
endpackage : ppwp_pkg

// ===== ppwp_guard.sv
// Guard that grants or refuses writes aimed at the protected peripherals.
module ppwp_guard (
    input wire logic [31:0] prot_state,
    input wire logic periph_wr_valid,
    input wire logic [ppwp_pkg::IDX_W-1:0] periph_wr_index,
    output logic periph_wr_grant,
    output logic periph_wr_err
);
    logic owned;
    logic locked;

    // A write to a protected peripheral loses its data and is answered with an error.
    always_comb begin
        owned = ppwp_pkg::PROT_MASK[periph_wr_index];
        locked = owned && prot_state[periph_wr_index];
        periph_wr_err = periph_wr_valid && locked;
        periph_wr_grant = periph_wr_valid && !locked;
    end
endmodule : ppwp_guard

// ===== ppwp_ctrl.sv
// Protection state register pair with its register port and the peripheral write guard.

// Contract
// - Writing zero to a clear bit leaves that peripheral's protection unchanged.
// - Writing one to a clear bit removes that peripheral's protection.
// - Timer/counter 0..7 protection sits at bits 8..15, ascending.
// - Serial units 0..5 protection sits at bits 2..7, ascending.
// - Clear and set registers read back the same protection value.
// - Writes to a protected peripheral are discarded and answered with an error.
// - Setting an already protected peripheral answers with an access error.
module ppwp_ctrl (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppwp_pkg::ADDR_W-1:0] paddr,
    input wire logic [ppwp_pkg::DATA_W-1:0] pwdata,
    input wire logic [ppwp_pkg::STRB_W-1:0] pstrb,
    output logic [ppwp_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic periph_wr_valid,
    input wire logic [ppwp_pkg::IDX_W-1:0] periph_wr_index,
    output logic periph_wr_grant,
    output logic periph_wr_err,
    output logic event_system_protect_bit,
    output logic [ppwp_pkg::SERIAL_N-1:0] serial_unit_protect_bits,
    output logic [ppwp_pkg::TIMER_N-1:0] timer_counter_protect_bits,
    output logic [ppwp_pkg::ANALOG_N-1:0] analog_protect_bits,
    output logic touch_sensing_protect_bit
);
    logic [31:0] state_r;
    logic [31:0] state_nxt;
    logic [31:0] prdata_r;
    logic [31:0] wmask;
    logic access;
    logic wr_acc;
    logic clr_hit;
    logic set_hit;
    logic mapped;
    logic dbl_set;

    // Expands byte strobes into a bit mask; shared by both write paths.
    function automatic logic [31:0] strb_to_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strb_to_mask

    // Register select; one compare feeds the write strobes, the read decode and the error.
    function automatic logic addr_hits(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : addr_hits

    // Decode of the access phase; a single-cycle access phase keeps the port wait-free.
    always_comb begin
        access = psel && penable;
        wr_acc = access && pwrite;
        mapped = addr_hits(paddr, ppwp_pkg::OFF_CLEAR) || addr_hits(paddr, ppwp_pkg::OFF_SET);
        clr_hit = wr_acc && addr_hits(paddr, ppwp_pkg::OFF_CLEAR);
        set_hit = wr_acc && addr_hits(paddr, ppwp_pkg::OFF_SET);
        wmask = pwdata & strb_to_mask(pstrb) & ppwp_pkg::PROT_MASK;
        dbl_set = set_hit && ((wmask & state_r) != 32'h00000000);
    end

    // Next protection state; a refused set leaves every bit as it was.
    always_comb begin
        state_nxt = state_r;
        if (clr_hit) begin
            state_nxt = state_r & ~wmask;
        end else if (set_hit && !dbl_set) begin
            state_nxt = state_r | wmask;
        end
    end

    // Protection state flip-flops.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= ppwp_pkg::STATE_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Read data is caught in the setup phase so that it leaves a flip-flop.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (mapped) begin
                prdata_r <= (state_r & ppwp_pkg::PROT_MASK) | ppwp_pkg::FIXED_READ;
            end else begin
                prdata_r <= 32'h00000000;
            end
        end
    end

    // Handshake: never waits; error for unmapped addresses and double protection.
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || dbl_set);
    assign prdata = prdata_r;

    // Per-peripheral views of the state, in ascending bit order.
    assign event_system_protect_bit = state_r[ppwp_pkg::EVENT_BIT];
    assign serial_unit_protect_bits = state_r[ppwp_pkg::SERIAL_LSB +: ppwp_pkg::SERIAL_N];
    assign timer_counter_protect_bits = state_r[ppwp_pkg::TIMER_LSB +: ppwp_pkg::TIMER_N];
    assign analog_protect_bits = state_r[ppwp_pkg::ANALOG_LSB +: ppwp_pkg::ANALOG_N];
    assign touch_sensing_protect_bit = state_r[ppwp_pkg::TOUCH_BIT];

    // Guard on the peripheral side of the bridge.
    ppwp_guard u_guard (
        .prot_state(state_r),
        .periph_wr_valid(periph_wr_valid),
        .periph_wr_index(periph_wr_index),
        .periph_wr_grant(periph_wr_grant),
        .periph_wr_err(periph_wr_err)
    );

    // All checks run on the one bus clock and rest while reset is held.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence rd_setup_s(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence rd_access_s;
        psel && penable && !pwrite;
    endsequence
    // Write transfer in its two steps, to follow a set through to the state.
    sequence wr_setup_s(logic [7:0] a);
        psel && !penable && pwrite && paddr == a;
    endsequence
    sequence wr_access_s;
        psel && penable && pwrite;
    endsequence

    // Clear writes: zero bits hold, one bits drop, and the timer and serial fields land on their own bits.
    AST_CLR_ZERO_KEEPS: assert property (clr_hit |=>
        ((state_r ^ $past(state_r)) & ~$past(wmask)) == 32'h00000000)
        else $error("Clear write changed a bit written as zero.");
    AST_CLR_ONE_CLEARS: assert property (clr_hit |=>
        (state_r & $past(wmask)) == 32'h00000000)
        else $error("Clear write left a bit protected.");
    AST_TIMER_MAP: assert property (clr_hit && pstrb[1] && pwdata[15] |=>
        !timer_counter_protect_bits[7])
        else $error("Timer seven not cleared by bit fifteen.");
    AST_SERIAL_MAP: assert property (clr_hit && pstrb[0] && pwdata[2] |=>
        !serial_unit_protect_bits[0])
        else $error("Serial unit zero not cleared by bit two.");

    // Both registers read back the state caught at the end of the setup phase.
    AST_SAME_READ: assert property ((rd_setup_s(ppwp_pkg::OFF_SET) or
        rd_setup_s(ppwp_pkg::OFF_CLEAR)) ##1 rd_access_s |->
        prdata == ($past(state_r) | ppwp_pkg::FIXED_READ))
        else $error("Read value differs from protection state.");

    // A protected peripheral never sees the write that aims at it.
    AST_PROT_WRITE_ERR: assert property (periph_wr_valid &&
        state_r[periph_wr_index] && ppwp_pkg::PROT_MASK[periph_wr_index] |->
        periph_wr_err && !periph_wr_grant)
        else $error("Write to protected peripheral was granted.");

    // A double protection is refused whole, so a half-applied set cannot hide the fault.
    AST_DOUBLE_SET: assert property (set_hit && ((wmask & state_r) != 32'h00000000) |->
        pslverr ##1 $stable(state_r))
        else $error("Double protection not refused.");

    // Only the fixed bit may read as one outside the peripheral fields.
    AST_RESERVED_ZERO: assert property (rd_access_s |->
        (prdata & ~(ppwp_pkg::PROT_MASK | ppwp_pkg::FIXED_READ)) == 32'h00000000)
        else $error("Unassigned bits read non-zero.");

    // A set write that is not refused protects every lane-enabled one bit of a peripheral field.
    AST_SET_PROTECTS: assert property (
        wr_setup_s(ppwp_pkg::OFF_SET) ##1 (wr_access_s ##0 !dbl_set) |=>
        (state_r & $past(wmask)) == $past(wmask))
        else $error("Set write left a written bit unprotected.");

    // The error answer stands only in an access cycle, and a clean set carries none.
    AST_SET_ERR_ONLY_DOUBLE: assert property (set_hit && !dbl_set |-> !pslverr)
        else $error("Set write answered with an error without double protection.");
    AST_ERR_ONLY_ACCESS: assert property (!access |-> !pslverr)
        else $error("Error answer outside an access cycle.");

    // Without a register write the protection state must not move.
    AST_IDLE_HOLDS: assert property (!clr_hit && !set_hit |=> $stable(state_r))
        else $error("Protection state moved without a register write.");

    // Event and touch bits each answer to their own bit of a clear write.
    AST_EVENT_MAP: assert property (clr_hit && pstrb[0] && pwdata[ppwp_pkg::EVENT_BIT] |=>
        !event_system_protect_bit)
        else $error("Event system bit not cleared by its clear bit.");
    AST_TOUCH_MAP: assert property (clr_hit && pstrb[2] && pwdata[ppwp_pkg::TOUCH_BIT] |=>
        !touch_sensing_protect_bit)
        else $error("Touch sensing bit not cleared by its clear bit.");

    // Lanes let software free one field without touching the rest of the register.
    AST_LANE_GATED: assert property (clr_hit && !pstrb[1] |=>
        $stable(timer_counter_protect_bits))
        else $error("Clear write changed a lane that was not strobed.");

    // Unmapped addresses answer with an error, read as zero and never reach the state.
    AST_UNMAPPED_ERR: assert property (access && !mapped |-> pslverr)
        else $error("Unmapped access answered without an error.");
    AST_UNMAPPED_HOLDS: assert property (wr_acc && !mapped |=> $stable(state_r))
        else $error("Unmapped write changed the protection state.");
    AST_UNMAPPED_READ: assert property (
        (psel && !penable && !pwrite && !mapped) ##1 rd_access_s |-> prdata == 32'h00000000)
        else $error("Unmapped read returned non-zero data.");

    // A write to an unprotected or unowned peripheral passes untouched.
    AST_FREE_WRITE_GRANT: assert property (periph_wr_valid &&
        !(state_r[periph_wr_index] && ppwp_pkg::PROT_MASK[periph_wr_index]) |->
        periph_wr_grant && !periph_wr_err)
        else $error("Write to unprotected peripheral was refused.");

    // Without a request the guard answers neither way.
    AST_GUARD_IDLE: assert property (!periph_wr_valid |->
        !periph_wr_grant && !periph_wr_err)
        else $error("Guard answered without a request.");
endmodule : ppwp_ctrl

// ===== peripheral_write_protect_clear_tb.sv
// Self-checking testbench for the peripheral write-protection register pair.
module peripheral_write_protect_clear_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wr_valid = 1'b0;
    logic [4:0] wr_index = 5'h00;
    logic grant;
    logic err;
    logic event_bit;
    logic [5:0] serial_bits;
    logic [7:0] timer_bits;
    logic [2:0] analog_bits;
    logic touch_bit;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int n_checks = 0;
    localparam logic [31:0] ALL = ppwp_pkg::RESET_VALUE | ppwp_pkg::PROT_MASK;
    // An address that selects neither register.
    localparam logic [7:0] OFF_NONE = 8'h08;
    ppwp_ctrl u_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_wr_valid(wr_valid),
        .periph_wr_index(wr_index), .periph_wr_grant(grant), .periph_wr_err(err),
        .event_system_protect_bit(event_bit), .serial_unit_protect_bits(serial_bits),
        .timer_counter_protect_bits(timer_bits), .analog_protect_bits(analog_bits),
        .touch_sensing_protect_bit(touch_bit));
    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clock = ~clock;
    end
    // Compares one value and counts the outcome.
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One APB transfer; inputs move 1 ns after the edge so sampling never races.
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock);
        #1;
        psel = 1'b1;
        penable = 1'b0;
        pwrite = wr;
        paddr = addr;
        pwdata = data;
        @(posedge clock);
        #1;
        penable = 1'b1;
        // The answer is taken mid-cycle, while it stands, then held through the closing edge.
        @(negedge clock);
        rd = prdata;
        er = pslverr;
        chk("pready", {31'h0, pready}, 32'h00000001);
        @(posedge clock);
        #1;
        psel = 1'b0;
        penable = 1'b0;
    endtask : apb
    // Both registers must show one and the same state.
    task read_both(input logic [31:0] exp);
        apb(1'b0, ppwp_pkg::OFF_CLEAR, 32'h00000000);
        chk("clear read", rd, exp);
        apb(1'b0, ppwp_pkg::OFF_SET, 32'h00000000);
        chk("set read", rd, exp);
    endtask : read_both
    // Guard answer is combinational; it is judged mid-cycle while the request stands.
    task guard(input logic [4:0] idx, input logic [1:0] exp);
        @(posedge clock);
        #1;
        wr_valid = 1'b1;
        wr_index = idx;
        @(negedge clock);
        chk("guard err,grant", {30'h0, err, grant}, {30'h0, exp});
        @(posedge clock);
        #1;
        wr_valid = 1'b0;
    endtask : guard
    // Protect everything, then a second protect of one timer must be refused.
    task t_set_twice();
        apb(1'b1, ppwp_pkg::OFF_SET, ppwp_pkg::PROT_MASK);
        chk("set err", {31'h0, er}, 32'h00000000);
        read_both(ALL);
        apb(1'b1, ppwp_pkg::OFF_SET, 32'h00000200);
        chk("double set err", {31'h0, er}, 32'h00000001);
        read_both(ALL);
        guard(5'h09, 2'b10);
    endtask : t_set_twice
    // Zero writes change nothing; ones free exactly timer 1 and serial unit 0.
    task t_clear();
        apb(1'b1, ppwp_pkg::OFF_CLEAR, 32'h00000000);
        read_both(ALL);
        apb(1'b1, ppwp_pkg::OFF_CLEAR, 32'h00000204);
        read_both(ALL & ~32'h00000204);
        chk("timer bits", {24'h0, timer_bits}, 32'h000000FD);
        chk("serial bits", {26'h0, serial_bits}, 32'h0000003E);
        guard(5'h09, 2'b01);
    endtask : t_clear
    // Bits that own no peripheral keep their fixed value whatever is written.
    task t_unassigned();
        apb(1'b1, OFF_NONE, 32'hFFFFFFFF);
        chk("unmapped write err", {31'h0, er}, 32'h00000001);
        apb(1'b0, OFF_NONE, 32'h00000000);
        chk("unmapped read", rd, 32'h00000000);
        chk("unmapped read err", {31'h0, er}, 32'h00000001);
        read_both(ALL & ~32'h00000204);
        apb(1'b1, ppwp_pkg::OFF_CLEAR, 32'hFFFFFFFF);
        apb(1'b1, ppwp_pkg::OFF_SET, 32'hFFF00001);
        read_both(ppwp_pkg::RESET_VALUE);
    endtask : t_unassigned
    // Event, analog and touch views follow the state; a mid-run reset restores it.
    task t_views_reset();
        apb(1'b1, ppwp_pkg::OFF_SET, 32'h00090002);
        chk("touch,analog", {28'h0, touch_bit, analog_bits}, 32'h00000009);
        chk("event bit", {31'h0, event_bit}, 32'h00000001);
        pstrb = 4'h4;
        apb(1'b1, ppwp_pkg::OFF_CLEAR, 32'h00090002);
        pstrb = 4'hF;
        chk("lane clear", {28'h0, touch_bit, analog_bits}, 32'h00000000);
        chk("event bit kept", {31'h0, event_bit}, 32'h00000001);
        @(posedge clock);
        #1;
        resetn = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        resetn = 1'b1;
        read_both(ppwp_pkg::RESET_VALUE);
    endtask : t_views_reset
    // Prints the verdict and stops the run.
    task end_of_test();
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // Watchdog sized well above the hundred or so cycles the tests need.
    initial begin
        #20000;
        fails++;
        end_of_test();
    end
    // Main sequence: two cycles of reset, then the scenarios.
    initial begin
        repeat (2) @(posedge clock);
        #1;
        resetn = 1'b1;
        read_both(ppwp_pkg::RESET_VALUE);
        t_set_twice();
        t_clear();
        t_unassigned();
        t_views_reset();
        end_of_test();
    end
endmodule : peripheral_write_protect_clear_tb
